/* File: dv/sbdb_remote_tx.sv */
// sbdb_remote_tx: far-end serial transmitter driving the receive line.
// assumes the caller runs on clk edges and passes the bit time in cycles.
`timescale 1ns/1ps
`default_nettype none
module sbdb_remote_tx (
  // clock
  input  wire logic clk,
  // serial line, idles high
  output var  logic rxd
);
  initial rxd = 1'b1;

  // line level held until the next call
  task automatic drive(input logic v, input int n);
    rxd <= v;
    repeat (n) @(posedge clk);
  endtask

  // start, data lsb first, one stop bit
  task automatic frame(input logic [8:0] d, input int nb, input int bl);
    int k;
    drive(1'b0, bl);
    for (k = 0; k < nb; k++) drive(d[k], bl);
    drive(1'b1, bl);
  endtask
endmodule
`default_nettype wire

/* File: dv/sbdb_top_sva.sv */
// sbdb_top_sva: bus and serial timing checks on the top ports.
// assumes one clock; baud writes seen at the ack edge.
`timescale 1ns/1ps
`default_nettype none
module sbdb_top_sva
  import sbdb_pkg::*;
(
  // clock and reset
  input wire logic        CLK,
  input wire logic        RESET,
  // wishbone
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        WB_ERR_O,
  // serial
  input wire logic        RXD,
  input wire logic        TXD
);
  logic       req, mapped, txd_q;
  logic [7:0] baud_q, baud_d;
  int         run_q, run_d, pd, bl;

  assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
  assign mapped = WB_ADR_I inside {SBDB_ADDR_DATA, SBDB_ADDR_STAT1, SBDB_ADDR_STAT2,
                                   SBDB_ADDR_BAUD, SBDB_ADDR_CTRL3};

  always_comb begin
    baud_d = baud_q;
    if (WB_ACK_O && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == SBDB_ADDR_BAUD) begin
      baud_d = WB_DAT_I[7:0] & SBDB_BAUD_MASK;
    end
    run_d = (TXD != txd_q) ? 1 : run_q + 1;
    case (baud_q[5:4])
      2'h0: pd = 1;
      2'h1: pd = 3;
      2'h2: pd = 4;
      default: pd = 13;
    endcase
    bl = (64 * pd) << baud_q[2:0];
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      baud_q <= 8'h00;
      run_q  <= 0;
    end else begin
      baud_q <= baud_d;
      run_q  <= run_d;
    end
    txd_q <= TXD;
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence s_take;
    req && mapped;
  endsequence
  sequence s_take_bad;
    req && !mapped;
  endsequence

  a_ack_next: assert property (s_take |=> WB_ACK_O && !WB_ERR_O)
    else $error("mapped access not acked next cycle");
  a_err_next: assert property (s_take_bad |=> WB_ERR_O && !WB_ACK_O)
    else $error("unmapped access not refused");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_dat_quiet: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data outside ack");
  a_baud_read: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == SBDB_ADDR_BAUD
    |-> WB_DAT_O == {24'h0, baud_q}) else $error("baud readback wrong");
  a_stat2_width: assert property (WB_ACK_O && WB_ADR_I == SBDB_ADDR_STAT2
    |-> WB_DAT_O[31:2] == 30'h0) else $error("status two spare bits set");
  a_low_run: assert property (TXD && !txd_q |-> run_q % bl == 0)
    else $error("tx low run not whole bits");
  a_txd_reset: assert property ($fell(RESET) |-> TXD && !WB_ACK_O)
    else $error("outputs not idle after reset");
endmodule

bind sbdb_top sbdb_top_sva i_sva (.CLK, .RESET, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
  .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .WB_ERR_O, .RXD, .TXD);
`default_nettype wire

/* File: dv/sbdb_top_tb.sv */
// sbdb_top_tb: register, transmit and receive checks of sbdb_top.
// assumes the remote transmitter model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module sbdb_top_tb
  import sbdb_pkg::*;
;
  logic        CLK, RESET, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, WB_ERR_O, RXD, TXD, er;
  logic [7:0]  WB_ADR_I, r;
  logic [3:0]  WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O;
  int          n_errors = 0, check_count = 0, i, bl;
  int          pdt[4] = '{1, 3, 4, 13};

  sbdb_top i_dut (.CLK, .RESET, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I,
    .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .WB_ERR_O, .RXD, .TXD);
  sbdb_remote_tx i_rtx (.clk(CLK), .rxd(RXD));

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int k;
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= {24'h0, d};
    for (k = 0; k < 16; k++) begin
      @(posedge CLK);
      if (WB_ACK_O === 1'b1 || WB_ERR_O === 1'b1) break;
    end
    if (k == 16) begin
      n_errors++;
      print_verdict();
    end else begin
      r = WB_DAT_O[7:0];
      er = WB_ERR_O;
      WB_CYC_I <= 1'b0;
      WB_STB_I <= 1'b0;
      @(posedge CLK);
    end
  endtask

  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] m, e);
    wb(1'b0, a, 8'h00);
    `CHK(n, e, r & m)
  endtask

  // no fall within a bit time leaves s wrong, so a hang shows as a mismatch
  task automatic txchk(input int b, input logic [7:0] e);
    int k;
    logic [9:0] s;
    for (k = 0; k < b; k++) begin
      @(posedge CLK);
      if (TXD === 1'b0) break;
    end
    repeat (b / 2) @(posedge CLK);
    for (k = 0; k < 10; k++) begin
      s[k] = TXD;
      repeat (b) @(posedge CLK);
    end
    `CHK("tx frame", {1'b1, e, 1'b0}, s)
  endtask

  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  initial begin
    RESET = 1'b1;
    WB_CYC_I = 1'b0;
    WB_STB_I = 1'b0;
    WB_WE_I = 1'b0;
    WB_ADR_I = 8'h00;
    WB_SEL_I = 4'h1;
    WB_DAT_I = 32'h0;
    repeat (4) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    rc("baud rst", SBDB_ADDR_BAUD, 8'hff, 8'h00);
    rc("stat2 rst", SBDB_ADDR_STAT2, 8'h03, 8'h00);
    wb(1'b1, SBDB_ADDR_STAT2, 8'hff);
    rc("stat2 ro", SBDB_ADDR_STAT2, 8'h03, 8'h00);
    wb(1'b1, SBDB_ADDR_BAUD, 8'hff);
    rc("baud fields", SBDB_ADDR_BAUD, 8'hff, 8'h37);
    wb(1'b0, 8'h40, 8'h00);
    `CHK("unmapped", 1'b1, er)
    for (i = 0; i < 4; i++) begin
      bl = 64 * pdt[i] * (1 << (3 - i));
      wb(1'b1, SBDB_ADDR_BAUD, 8'(i * 16 + 3 - i));
      wb(1'b1, SBDB_ADDR_DATA, 8'h3c ^ 8'(i));
      txchk(bl, 8'h3c ^ 8'(i));
    end
    bl = 192;
    wb(1'b1, SBDB_ADDR_BAUD, 8'h10);
    wb(1'b1, SBDB_ADDR_CTRL3, 8'h01);
    fork
      i_rtx.frame(9'h15a, 9, bl);
      begin
        repeat (bl * 2) @(posedge CLK);
        rc("active", SBDB_ADDR_STAT2, 8'h01, 8'h01);
      end
    join
    i_rtx.drive(1'b1, bl * 12);
    rc("full", SBDB_ADDR_STAT1, 8'h20, 8'h20);
    rc("rx data", SBDB_ADDR_DATA, 8'hff, 8'h5a);
    rc("ninth", SBDB_ADDR_CTRL3, 8'h80, 8'h80);
    rc("idle", SBDB_ADDR_STAT2, 8'h01, 8'h00);
    RESET <= 1'b1;
    repeat (4) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    rc("data kept", SBDB_ADDR_DATA, 8'hff, 8'h5a);
    rc("baud clr", SBDB_ADDR_BAUD, 8'hff, 8'h00);
    wb(1'b1, SBDB_ADDR_BAUD, 8'h10);
    wb(1'b1, SBDB_ADDR_CTRL3, 8'h01);
    fork
      i_rtx.drive(1'b0, bl / 4);
      begin
        repeat (bl / 8) @(posedge CLK);
        rc("rpf set", SBDB_ADDR_STAT2, 8'h01, 8'h01);
      end
    join
    i_rtx.drive(1'b1, bl * 12);
    rc("false start", SBDB_ADDR_STAT2, 8'h01, 8'h00);
    i_rtx.drive(1'b0, bl * 12);
    rc("brk fe full", SBDB_ADDR_STAT1, 8'h22, 8'h22);
    rc("brk ninth", SBDB_ADDR_CTRL3, 8'h80, 8'h00);
    wb(1'b0, SBDB_ADDR_DATA, 8'h00);
    rc("brk set", SBDB_ADDR_STAT2, 8'h02, 8'h02);
    wb(1'b0, SBDB_ADDR_DATA, 8'h00);
    rc("brk clr", SBDB_ADDR_STAT2, 8'h02, 8'h00);
    i_rtx.drive(1'b0, bl * 20);
    rc("no rearm", SBDB_ADDR_STAT2, 8'h02, 8'h00);
    // long enough for a reception in flight to end and idle to rearm
    i_rtx.drive(1'b1, bl * 12);
    i_rtx.drive(1'b0, bl * 12);
    rc("rearm", SBDB_ADDR_STAT2, 8'h02, 8'h02);
    i_rtx.drive(1'b1, bl * 2);
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: src/sbdb_baud_gen.sv */
// sbdb_baud_gen: sample tick generator, 16 ticks per bit time.
// assumes the crystal clock is the module clock; settings come from
// registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
module sbdb_baud_gen
  import sbdb_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // settings
  input  wire sbdb_baud_t baud,
  // sample tick
  output logic            tick_q
);

  logic [1:0] pre4_q,  pre4_d;
  logic [3:0] pd_q,    pd_d;
  logic [6:0] bd_q,    bd_d;
  logic       tick_d;
  logic [3:0] pd_lim;
  logic [6:0] bd_lim;

  always_comb begin
    unique case (baud.pre)
      2'b00: pd_lim = SBDB_PD_CODE0 - 4'h1;
      2'b01: pd_lim = SBDB_PD_CODE1 - 4'h1;
      2'b10: pd_lim = SBDB_PD_CODE2 - 4'h1;
      2'b11: pd_lim = SBDB_PD_CODE3 - 4'h1;
    endcase
    bd_lim = 7'((8'h01 << baud.rate) - 8'h01);
  end

  // cascaded /4, /pd, /bd then 16 slots
  always_comb begin
    pre4_d = pre4_q + 2'h1;
    pd_d   = pd_q;
    bd_d   = bd_q;
    tick_d = 1'b0;
    if (pre4_q == 2'(SBDB_SAMPLE_PRE - 1)) begin
      pd_d = (pd_q >= pd_lim) ? 4'h0 : pd_q + 4'h1;
      if (pd_q >= pd_lim) begin
        bd_d = (bd_q >= bd_lim) ? 7'h00 : bd_q + 7'h01;
        tick_d = (bd_q >= bd_lim);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pre4_q <= 2'h0;
      pd_q   <= 4'h0;
      bd_q   <= 7'h00;
      tick_q <= 1'b0;
    end else begin
      pre4_q <= pre4_d;
      pd_q   <= pd_d;
      bd_q   <= bd_d;
      tick_q <= tick_d;
    end
  end

endmodule
`default_nettype wire

/* File: src/sbdb_pkg.sv */
// sbdb_pkg: register map, field layout, reset values and timing constants
// for the serial break, data buffer and baud rate block.
// assumes a 32-bit classic wishbone register bus, byte addresses.
package sbdb_pkg;

  // register byte addresses (0x0018 printed; others placed beside it)
  localparam logic [7:0] SBDB_ADDR_DATA    = 8'h18;
  localparam logic [7:0] SBDB_ADDR_STAT1   = 8'h1c;
  localparam logic [7:0] SBDB_ADDR_STAT2   = 8'h20;
  localparam logic [7:0] SBDB_ADDR_BAUD    = 8'h24;
  localparam logic [7:0] SBDB_ADDR_CTRL3   = 8'h28;

  // baud_rate_select fields
  localparam int SBDB_BAUD_RATE_LSB = 0;
  localparam int SBDB_BAUD_PRE_LSB  = 4;
  localparam logic [7:0] SBDB_BAUD_RESET = 8'h00;
  localparam logic [7:0] SBDB_BAUD_MASK  = 8'h37;

  // serial_status_two bit positions
  localparam int SBDB_S2_BREAK  = 1;
  localparam int SBDB_S2_ACTIVE = 0;
  // serial_status_one bit positions
  localparam int SBDB_S1_FULL  = 5;
  localparam int SBDB_S1_FRAME = 1;
  // serial_control_three bit positions
  localparam int SBDB_C3_NINTH_RX = 7;
  localparam int SBDB_C3_NINTH_TX = 6;
  localparam int SBDB_C3_NINE_BIT = 0;

  // baud formula: crystal / (64 * prescale_divisor * rate_divisor)
  localparam int SBDB_BAUD_BASE_DIV = 64;
  localparam int SBDB_SAMPLES_PER_BIT = 16;
  // the 64 splits into a fixed /4 sample clock and 16 sample slots per bit
  localparam int SBDB_SAMPLE_PRE = SBDB_BAUD_BASE_DIV / SBDB_SAMPLES_PER_BIT;
  localparam logic [3:0] SBDB_PD_CODE0 = 4'h1;
  localparam logic [3:0] SBDB_PD_CODE1 = 4'h3;
  localparam logic [3:0] SBDB_PD_CODE2 = 4'h4;
  localparam logic [3:0] SBDB_PD_CODE3 = 4'hd;
  localparam logic [3:0] SBDB_SLOT_SAMPLE = 4'h8;
  localparam logic [3:0] SBDB_SLOT_LAST   = 4'hf;
  localparam logic [3:0] SBDB_IDLE_BITS   = 4'ha;
  localparam logic [3:0] SBDB_FRAME_BITS8 = 4'h9;
  localparam logic [3:0] SBDB_FRAME_BITS9 = 4'ha;

  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } sbdb_wb_req_t;

  typedef struct packed {
    logic [1:0] pre;
    logic [2:0] rate;
  } sbdb_baud_t;

endpackage

/* File: src/sbdb_top.sv */
// sbdb_top: break and reception flags, data buffer, baud generator and
// a compact receiver/transmitter around them, on a wishbone slave.
// assumes RXD is asynchronous to CLK; CLK is the crystal clock.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sbdb_top
  import sbdb_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             WB_ERR_O,
  // serial pins
  input  wire logic        RXD,
  output logic             TXD
);

  typedef enum logic [1:0] {
    SBDB_RX_IDLE  = 2'b00,
    SBDB_RX_START = 2'b01,
    SBDB_RX_DATA  = 2'b10
  } sbdb_rx_st_t;

  typedef enum logic [0:0] {
    SBDB_TX_IDLE = 1'b0,
    SBDB_TX_SHIFT = 1'b1
  } sbdb_tx_st_t;

  sbdb_wb_req_t req;
  assign req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, adr: WB_ADR_I,
                 sel: WB_SEL_I, dat: WB_DAT_I};

  logic rx_m_q, rx_s_q;
  logic tick;

  // bus and registers
  logic [31:0] dat_q, dat_d;
  logic        ack_q, ack_d, err_q, err_d;
  logic [7:0]  rx_buf_q, rx_buf_d, tx_buf_q, tx_buf_d;
  logic        tx_pend_q, tx_pend_d;
  sbdb_baud_t  baud_q, baud_d;
  logic        nine_q, nine_d, t8_q, t8_d, r8_q, r8_d;
  logic        brk_q, brk_d, full_q, full_d, fe_q, fe_d;
  logic        brk_armed_q, brk_armed_d, s2_seen_q, s2_seen_d, s1_seen_q, s1_seen_d;
  logic        active_q, active_d;
  // receiver
  sbdb_rx_st_t rx_st_q, rx_st_d;
  logic [3:0]  rslot_q, rslot_d, rbit_q, rbit_d, ones_q, ones_d;
  logic [8:0]  rsh_q, rsh_d;
  // transmitter
  sbdb_tx_st_t tx_st_q, tx_st_d;
  logic [3:0]  tslot_q, tslot_d, tbit_q, tbit_d;
  logic [10:0] tsh_q, tsh_d;
  logic        txd_q, txd_d;

  logic        acc, rd_data, rd_s1, rd_s2, wr_data;
  logic [3:0]  frame_bits;

  // single generator shared by both directions
  sbdb_baud_gen u_baud (
    .clk    (CLK),
    .reset  (RESET),
    .baud   (baud_q),
    .tick_q (tick)
  );

  assign acc        = req.cyc && req.stb && !ack_q && !err_q;
  assign rd_data    = acc && !req.we && req.adr == SBDB_ADDR_DATA;
  assign wr_data    = acc && req.we && req.adr == SBDB_ADDR_DATA && req.sel[0];
  assign rd_s1      = acc && !req.we && req.adr == SBDB_ADDR_STAT1;
  assign rd_s2      = acc && !req.we && req.adr == SBDB_ADDR_STAT2;
  assign frame_bits = nine_q ? SBDB_FRAME_BITS9 : SBDB_FRAME_BITS8;

  // bus slave: one wait state, ack or err in the cycle after the request
  always_comb begin
    ack_d  = 1'b0;
    err_d  = 1'b0;
    dat_d  = 32'h0000_0000;
    baud_d = baud_q;
    nine_d = nine_q;
    t8_d   = t8_q;
    if (acc) begin
      unique case (req.adr)
        SBDB_ADDR_DATA:  begin
          ack_d = 1'b1;
          dat_d = {24'h0, rx_buf_q};
        end
        SBDB_ADDR_STAT1: begin
          ack_d = 1'b1;
          dat_d[SBDB_S1_FULL]  = full_q;
          dat_d[SBDB_S1_FRAME] = fe_q;
        end
        // status two has no write effect
        SBDB_ADDR_STAT2: begin
          ack_d = 1'b1;
          dat_d[SBDB_S2_BREAK]  = brk_q;
          dat_d[SBDB_S2_ACTIVE] = active_q;
        end
        SBDB_ADDR_BAUD:  begin
          ack_d = 1'b1;
          dat_d = {26'h0, baud_q.pre, 1'b0, baud_q.rate};
          if (req.we && req.sel[0]) begin
            baud_d.pre  = req.dat[SBDB_BAUD_PRE_LSB +: 2];
            baud_d.rate = req.dat[SBDB_BAUD_RATE_LSB +: 3];
          end
        end
        SBDB_ADDR_CTRL3: begin
          ack_d = 1'b1;
          dat_d[SBDB_C3_NINTH_RX] = r8_q;
          dat_d[SBDB_C3_NINTH_TX] = t8_q;
          dat_d[SBDB_C3_NINE_BIT] = nine_q;
          if (req.we && req.sel[0]) begin
            t8_d   = req.dat[SBDB_C3_NINTH_TX];
            nine_d = req.dat[SBDB_C3_NINE_BIT];
          end
        end
        default: err_d = 1'b1;
      endcase
    end
  end

  // receiver with break and idle detection
  always_comb begin
    rx_st_d  = rx_st_q;
    rslot_d  = rslot_q;
    rbit_d   = rbit_q;
    rsh_d    = rsh_q;
    ones_d   = ones_q;
    rx_buf_d = rx_buf_q;
    r8_d     = r8_q;
    full_d   = full_q;
    fe_d     = fe_q;
    brk_d    = brk_q;
    brk_armed_d = brk_armed_q;
    active_d = active_q;
    s1_seen_d = s1_seen_q;
    s2_seen_d = s2_seen_q;
    if (rd_s2 && brk_q) begin
      s2_seen_d = 1'b1;
    end
    if (rd_s1 && (full_q || fe_q)) begin
      s1_seen_d = 1'b1;
    end
    if (rd_data) begin
      if (s2_seen_q) begin
        brk_d = 1'b0;
      end
      if (s1_seen_q) begin
        full_d = 1'b0;
        fe_d   = 1'b0;
      end
      s1_seen_d = 1'b0;
      s2_seen_d = 1'b0;
    end
    if (tick) begin
      unique case (rx_st_q)
        SBDB_RX_IDLE: begin
          if (rx_s_q) begin
            ones_d = (ones_q == SBDB_IDLE_BITS) ? ones_q : ones_q + 4'h1;
            // a single high sample while idle rearms the break detector
            brk_armed_d = 1'b1;
          end else begin
            // low in the first sample slot
            active_d = 1'b1;
            rx_st_d  = SBDB_RX_START;
            rslot_d  = 4'h1;
          end
        end
        SBDB_RX_START: begin
          rslot_d = rslot_q + 4'h1;
          if (rslot_q == SBDB_SLOT_SAMPLE) begin
            if (rx_s_q) begin
              active_d = 1'b0;
              rx_st_d  = SBDB_RX_IDLE;
            end else begin
              rx_st_d = SBDB_RX_DATA;
              rbit_d  = 4'h0;
              rslot_d = 4'h0;
              rsh_d   = 9'h000;
            end
          end
        end
        SBDB_RX_DATA: begin
          rslot_d = rslot_q + 4'h1;
          if (rslot_q == SBDB_SLOT_LAST) begin
            rbit_d = rbit_q + 4'h1;
            if (rbit_q == frame_bits - 4'h1) begin
              // stop slot reached: hand over to the buffer
              rx_st_d = SBDB_RX_IDLE;
              ones_d  = 4'h0;
              full_d  = 1'b1;
              // nine shifts leave the byte low; eight leave it one place up
              rx_buf_d = nine_q ? rsh_q[7:0] : rsh_q[8:1];
              r8_d     = rsh_q[8];
              if (!rx_s_q) begin
                fe_d = 1'b1;
              end
              if (!rx_s_q && rsh_q == 9'h000) begin
                if (brk_armed_q) begin
                  brk_d = 1'b1;
                end
                brk_armed_d = 1'b0;
                // break also flags framing and full
                fe_d   = 1'b1;
                full_d = 1'b1;
                if (nine_q) begin
                  r8_d = 1'b0;
                end
              end
            end else begin
              rsh_d = {rx_s_q, rsh_q[8:1]};
            end
          end
        end
        default: rx_st_d = SBDB_RX_IDLE;
      endcase
      if (ones_q == SBDB_IDLE_BITS - 4'h1 && rx_st_q == SBDB_RX_IDLE && rx_s_q) begin
        active_d = 1'b0;
      end
    end
  end

  // transmitter: data written while busy waits in the buffer
  always_comb begin
    tx_st_d   = tx_st_q;
    tslot_d   = tslot_q;
    tbit_d    = tbit_q;
    tsh_d     = tsh_q;
    txd_d     = txd_q;
    tx_buf_d  = tx_buf_q;
    tx_pend_d = tx_pend_q;
    // writes feed the transmit side only
    if (wr_data) begin
      tx_buf_d  = req.dat[7:0];
      tx_pend_d = 1'b1;
    end
    if (tick) begin
      unique case (tx_st_q)
        SBDB_TX_IDLE: begin
          txd_d = 1'b1;
          if (tx_pend_q && !wr_data) begin
            tx_pend_d = 1'b0;
            tx_st_d   = SBDB_TX_SHIFT;
            tslot_d   = 4'h0;
            tbit_d    = 4'h0;
            tsh_d     = nine_q ? {1'b1, t8_q, tx_buf_q, 1'b0}
                               : {2'b11, tx_buf_q, 1'b0};
          end
        end
        SBDB_TX_SHIFT: begin
          txd_d   = tsh_q[0];
          tslot_d = tslot_q + 4'h1;
          if (tslot_q == SBDB_SLOT_LAST) begin
            tsh_d  = {1'b1, tsh_q[10:1]};
            tbit_d = tbit_q + 4'h1;
            if (tbit_q == frame_bits) begin
              tx_st_d = SBDB_TX_IDLE;
            end
          end
        end
        default: tx_st_d = SBDB_TX_IDLE;
      endcase
    end
  end

  // data buffers kept out of reset
  always_ff @(posedge CLK) begin
    rx_buf_q <= rx_buf_d;
    tx_buf_q <= tx_buf_d;
    r8_q     <= r8_d;
    t8_q     <= t8_d;
    rsh_q    <= rsh_d;
    tsh_q    <= tsh_d;
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      rx_m_q   <= 1'b1;
      rx_s_q   <= 1'b1;
      dat_q    <= 32'h0000_0000;
      ack_q    <= 1'b0;
      err_q    <= 1'b0;
      baud_q   <= SBDB_BAUD_RESET[6:2];
      nine_q   <= 1'b0;
      brk_q    <= 1'b0;
      full_q   <= 1'b0;
      fe_q     <= 1'b0;
      brk_armed_q <= 1'b1;
      s1_seen_q <= 1'b0;
      s2_seen_q <= 1'b0;
      active_q <= 1'b0;
      rx_st_q  <= SBDB_RX_IDLE;
      rslot_q  <= 4'h0;
      rbit_q   <= 4'h0;
      ones_q   <= 4'h0;
      tx_pend_q <= 1'b0;
      tx_st_q  <= SBDB_TX_IDLE;
      tslot_q  <= 4'h0;
      tbit_q   <= 4'h0;
      txd_q    <= 1'b1;
    end else begin
      rx_m_q   <= RXD;
      rx_s_q   <= rx_m_q;
      dat_q    <= dat_d;
      ack_q    <= ack_d;
      err_q    <= err_d;
      baud_q   <= baud_d;
      nine_q   <= nine_d;
      brk_q    <= brk_d;
      full_q   <= full_d;
      fe_q     <= fe_d;
      brk_armed_q <= brk_armed_d;
      s1_seen_q <= s1_seen_d;
      s2_seen_q <= s2_seen_d;
      active_q <= active_d;
      rx_st_q  <= rx_st_d;
      rslot_q  <= rslot_d;
      rbit_q   <= rbit_d;
      ones_q   <= ones_d;
      tx_pend_q <= tx_pend_d;
      tx_st_q  <= tx_st_d;
      tslot_q  <= tslot_d;
      tbit_q   <= tbit_d;
      txd_q    <= txd_d;
    end
  end

  // no interrupt output exists for either flag
  assign WB_DAT_O = dat_q;
  assign WB_ACK_O = ack_q;
  assign WB_ERR_O = err_q;
  assign TXD      = txd_q;

endmodule
`default_nettype wire
